/* File: eeh_pkg.sv */
// Package of the serial memory host controller: register map, field positions,
// timing counts, state encodings and the structs that carry grouped signals.
// Assumes a 125 MHz system clock and a bus master that writes registers over Wishbone.
package eeh_pkg;

	// Register byte offsets.
	localparam logic [8:0] OFS_CTRL = 9'h000;
	localparam logic [8:0] OFS_ADDR = 9'h004;
	localparam logic [8:0] OFS_STAT = 9'h008;
	localparam int BUF_SEL_BIT = 8;

	// Control register fields.
	localparam int CTRL_GO = 0;
	localparam int CTRL_RD = 1;
	localparam int CTRL_POLL = 2;
	localparam int CTRL_WP = 3;
	localparam int CTRL_CNT_LO = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Address register fields.
	localparam int ADDR_WORD_LO = 0;
	localparam int ADDR_CS_LO = 16;
	localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

	// Status register fields.
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_NACK = 2;
	localparam int STAT_TOUT = 3;

	// Link geometry.
	localparam int PAGE_BYTES = 64;
	localparam int IDX_W = 6;
	localparam int WADDR_W = 15;

	// Timing: system clock, serial clock and the longest internal write cycle.
	localparam int CLK_PERIOD_PS = 8000;
	localparam int SCL_PERIOD_NS = 2500;
	localparam int QUARTER_CYC = (SCL_PERIOD_NS * 1000 / 4 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WRITE_CYCLE_MS = 5;
	localparam longint WRITE_CYCLE_CYC_L = longint'(WRITE_CYCLE_MS) * 64'd1_000_000_000
		/ longint'(CLK_PERIOD_PS);
	localparam int WRITE_CYCLE_CYC = int'(WRITE_CYCLE_CYC_L);

	typedef enum logic [1:0] {
		EK_BIT = 2'b00,
		EK_START = 2'b01,
		EK_STOP = 2'b11
	} eeh_kind_t;

	typedef enum logic [3:0] {
		MS_IDLE = 4'b0000,
		MS_START = 4'b0001,
		MS_BYTE = 4'b0011,
		MS_LOAD = 4'b0010,
		MS_FETCH = 4'b0110,
		MS_STORE = 4'b0111,
		MS_STOP = 4'b0101,
		MS_DONE = 4'b0100
	} eeh_mstate_t;

	typedef enum logic [2:0] {
		SG_CTRL = 3'b000,
		SG_AHI = 3'b001,
		SG_ALO = 3'b011,
		SG_WDATA = 3'b010,
		SG_CTRLR = 3'b110,
		SG_RDATA = 3'b111,
		SG_POLL = 3'b101
	} eeh_stage_t;

	typedef struct packed {
		logic go;
		eeh_kind_t kind;
		logic tx;
	} eeh_cmd_t;

	typedef struct packed {
		logic done;
		logic rx;
	} eeh_rsp_t;

	typedef struct packed {
		logic en;
		logic we;
		logic [IDX_W-1:0] addr;
		logic [7:0] wdata;
	} eeh_mem_req_t;

	// Applies Wishbone byte selects to a register write.
	function automatic logic [31:0] sel_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

endpackage

/* File: eeh_page_mem.sv */
// Single-port byte store that holds one page of write data or read results.
// Assumes one owner at a time; read data appear from a register one cycle after en.
`timescale 1ns/1ps
module eeh_page_mem
	import eeh_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = PAGE_BYTES
) (
	input wire logic clk_i,
	input wire logic en_i,
	input wire logic we_i,
	input wire logic [$clog2(DEPTH)-1:0] addr_i,
	input wire logic [WIDTH-1:0] wdata_i,
	output logic [WIDTH-1:0] rdata_o
);

	logic [WIDTH-1:0] mem_ff [DEPTH];

	always_ff @(posedge clk_i) begin
		if (en_i) begin
			if (we_i) begin
				mem_ff[addr_i] <= wdata_i;
			end
			rdata_o <= mem_ff[addr_i];
		end
	end

endmodule

/* File: eeh_bit_engine.sv */
// Serial bit engine: issues Start, Stop and single data bits on the two-wire link.
// Assumes one command at a time; the next go comes only after done. The data pin is
// open drain, so it is only ever pulled low or released; the clock is driven push-pull.
`timescale 1ns/1ps
module eeh_bit_engine
	import eeh_pkg::*;
#(
	parameter int QUARTER = QUARTER_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire eeh_cmd_t cmd_i,
	output eeh_rsp_t rsp_o,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o,
	output logic sda_oe_n_o
);

	typedef struct packed {
		logic busy;
		eeh_kind_t kind;
		logic tx;
		logic [1:0] ph;
		logic [15:0] cnt;
		logic scl;
		logic rel;
		logic sync1;
		logic sync2;
		eeh_rsp_t rsp;
	} eeh_eng_t;

	localparam logic [15:0] QLAST = 16'(QUARTER - 1);

	eeh_eng_t st_ff;
	eeh_eng_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.sync1 = sda_i;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.rsp.done = 1'b0;
		if (!st_ff.busy) begin
			if (cmd_i.go) begin
				nxt_st.busy = 1'b1;
				nxt_st.kind = cmd_i.kind;
				nxt_st.tx = cmd_i.tx;
				nxt_st.ph = 2'd0;
				nxt_st.cnt = 16'h0000;
			end
		end else if (st_ff.cnt != QLAST) begin
			nxt_st.cnt = st_ff.cnt + 16'h0001;
		end else begin
			nxt_st.cnt = 16'h0000;
			nxt_st.ph = st_ff.ph + 2'd1;
			// Data bits only move while the clock is low; Start and Stop move the line while it is high.
			case (st_ff.ph)
				2'd0: begin
					nxt_st.scl = 1'b0;
					case (st_ff.kind)
						EK_BIT: nxt_st.rel = st_ff.tx;
						EK_START: nxt_st.rel = 1'b1;
						default: nxt_st.rel = 1'b0;
					endcase
				end
				2'd1: begin
					nxt_st.scl = 1'b1;
				end
				2'd2: begin
					case (st_ff.kind)
						EK_BIT: nxt_st.rsp.rx = st_ff.sync2;
						EK_START: nxt_st.rel = 1'b0;
						default: nxt_st.rel = 1'b1;
					endcase
				end
				default: begin
					// A Stop leaves both lines high, which is the idle bus.
					if (st_ff.kind != EK_STOP) begin
						nxt_st.scl = 1'b0;
					end
					nxt_st.busy = 1'b0;
					nxt_st.rsp.done = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '{busy: 1'b0, kind: EK_BIT, tx: 1'b1, ph: 2'd0, cnt: 16'h0000, scl: 1'b1,
				rel: 1'b1, sync1: 1'b1, sync2: 1'b1, rsp: '{done: 1'b0, rx: 1'b1}};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rsp_o = st_ff.rsp;
	assign scl_o = st_ff.scl;
	assign sda_o = 1'b0;
	assign sda_oe_n_o = st_ff.rel;

endmodule

/* File: eeh_host.sv */
// What this block does
// - Data bits change only while clock is low
// - Transfers begin from idle, both lines high
// - Start: data falls with clock high
// - Stop: data rises with clock high
// - One bit per clock pulse, sampled high
// - Master chooses byte count per transfer
// - Ninth clock pulse carries the acknowledge
// - Acknowledger holds data low through clock high
// - Master withholds acknowledge on last read byte
// - Two address bytes, high first, top ignored
//
// Host controller for a two-wire serial memory: Wishbone registers, command sequencer,
// page buffer and the serial bit engine. Assumes a single Wishbone master and pull-ups
// on the data line; clock stretching by the device is not supported.
//
// Chosen here: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module eeh_host
	import eeh_pkg::*;
#(
	parameter logic [3:0] DEV_TYPE_CODE = 4'h0,
	parameter int POLL_CYCLES = WRITE_CYCLE_CYC,
	parameter int QUARTER = QUARTER_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [8:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic scl_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	output logic wp_o
);

	// DEV_TYPE_CODE default is arbitrary; set it to the device family's type code.

	typedef struct packed {
		eeh_mstate_t ms;
		eeh_stage_t stage;
		logic wait_eng;
		logic [8:0] sh;
		logic [3:0] nbits;
		logic [IDX_W-1:0] idx;
		logic [31:0] timer;
		eeh_cmd_t cmd;
		eeh_mem_req_t mem;
		logic ack;
		logic [31:0] dat;
		logic [1:0] wb_ph;
		logic rd;
		logic poll;
		logic wp;
		logic [IDX_W-1:0] cnt;
		logic [WADDR_W-1:0] waddr;
		logic [2:0] cs;
		logic busy;
		logic done;
		logic nack;
		logic tout;
	} eeh_host_t;

	localparam logic [31:0] POLL_LAST = 32'(POLL_CYCLES - 1);

	eeh_host_t st_ff;
	eeh_host_t nxt_st;
	eeh_rsp_t eng_rsp;
	logic [7:0] mem_rdata;
	logic [31:0] ctrl_rd;
	logic [31:0] addr_rd;
	logic [31:0] stat_rd;
	logic [31:0] ctrl_new;
	logic [31:0] addr_new;
	logic req;
	logic done_set;

	eeh_bit_engine #(
		.QUARTER(QUARTER)
	) u_eng (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.cmd_i(st_ff.cmd),
		.rsp_o(eng_rsp),
		.sda_i(sda_i),
		.scl_o(scl_o),
		.sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o)
	);

	eeh_page_mem #(
		.WIDTH(8),
		.DEPTH(PAGE_BYTES)
	) u_mem (
		// Fed from the next state so that the byte stands on mem_rdata in the very
		// cycle after the request; a registered request would hand over stale data.
		.clk_i(clk_i),
		.en_i(nxt_st.mem.en),
		.we_i(nxt_st.mem.we),
		.addr_i(nxt_st.mem.addr),
		.wdata_i(nxt_st.mem.wdata),
		.rdata_o(mem_rdata)
	);

	// Builds the control byte; the direction bit picks read or write.
	function automatic logic [8:0] ctrl_byte(input logic [2:0] cs, input logic rd);
		return {DEV_TYPE_CODE, cs, rd, 1'b1};
	endfunction

	always_comb begin
		ctrl_rd = 32'h0000_0000;
		ctrl_rd[CTRL_RD] = st_ff.rd;
		ctrl_rd[CTRL_POLL] = st_ff.poll;
		ctrl_rd[CTRL_WP] = st_ff.wp;
		ctrl_rd[CTRL_CNT_LO +: IDX_W] = st_ff.cnt;
		addr_rd = 32'h0000_0000;
		addr_rd[ADDR_WORD_LO +: WADDR_W] = st_ff.waddr;
		addr_rd[ADDR_CS_LO +: 3] = st_ff.cs;
		stat_rd = 32'h0000_0000;
		stat_rd[STAT_BUSY] = st_ff.busy;
		stat_rd[STAT_DONE] = st_ff.done;
		stat_rd[STAT_NACK] = st_ff.nack;
		stat_rd[STAT_TOUT] = st_ff.tout;
		ctrl_new = sel_merge(ctrl_rd, wb_dat_i, wb_sel_i);
		addr_new = sel_merge(addr_rd, wb_dat_i, wb_sel_i);
	end

	assign req = wb_cyc_i && wb_stb_i && !st_ff.ack;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.ack = 1'b0;
		nxt_st.cmd.go = 1'b0;
		nxt_st.mem.en = 1'b0;
		nxt_st.mem.we = 1'b0;
		done_set = 1'b0;

		// Register side. The buffer belongs to the sequencer while busy, so buffer
		// accesses simply wait; that may last a whole write cycle when polling.
		if (req) begin
			if (wb_adr_i[BUF_SEL_BIT]) begin
				if (!st_ff.busy) begin
					if (st_ff.wb_ph == 2'd0) begin
						nxt_st.mem.en = 1'b1;
						nxt_st.mem.we = wb_we_i && wb_sel_i[0];
						nxt_st.mem.addr = wb_adr_i[2 +: IDX_W];
						nxt_st.mem.wdata = wb_dat_i[7:0];
						nxt_st.wb_ph = 2'd1;
					end else begin
						nxt_st.wb_ph = 2'd0;
						nxt_st.ack = 1'b1;
						nxt_st.dat = {24'h00_0000, mem_rdata};
					end
				end
			end else begin
				nxt_st.ack = 1'b1;
				nxt_st.dat = 32'h0000_0000;
				case ({wb_adr_i[8:2], 2'b00})
					OFS_CTRL: begin
						nxt_st.dat = ctrl_rd;
						if (wb_we_i && !st_ff.busy) begin
							nxt_st.rd = ctrl_new[CTRL_RD];
							nxt_st.poll = ctrl_new[CTRL_POLL];
							nxt_st.wp = ctrl_new[CTRL_WP];
							nxt_st.cnt = ctrl_new[CTRL_CNT_LO +: IDX_W];
							if (ctrl_new[CTRL_GO] && wb_sel_i[0]) begin
								nxt_st.busy = 1'b1;
								nxt_st.nack = 1'b0;
								nxt_st.tout = 1'b0;
								nxt_st.stage = SG_CTRL;
								nxt_st.ms = MS_START;
							end
						end
					end
					OFS_ADDR: begin
						nxt_st.dat = addr_rd;
						if (wb_we_i && !st_ff.busy) begin
							nxt_st.waddr = addr_new[ADDR_WORD_LO +: WADDR_W];
							nxt_st.cs = addr_new[ADDR_CS_LO +: 3];
						end
					end
					OFS_STAT: begin
						nxt_st.dat = stat_rd;
						if (wb_we_i && wb_sel_i[0] && wb_dat_i[STAT_DONE]) begin
							nxt_st.done = 1'b0;
						end
					end
					default: nxt_st.dat = 32'h0000_0000;
				endcase
			end
		end

		if (st_ff.stage == SG_POLL && st_ff.timer != POLL_LAST) begin
			nxt_st.timer = st_ff.timer + 32'h0000_0001;
		end

		case (st_ff.ms)
			MS_IDLE: begin
			end
			MS_START: begin
				if (!st_ff.wait_eng) begin
					nxt_st.cmd = '{go: 1'b1, kind: EK_START, tx: 1'b1};
					nxt_st.wait_eng = 1'b1;
				end else if (eng_rsp.done) begin
					nxt_st.wait_eng = 1'b0;
					nxt_st.sh = ctrl_byte(st_ff.cs, st_ff.stage == SG_CTRLR);
					nxt_st.nbits = 4'd9;
					nxt_st.ms = MS_BYTE;
				end
			end
			MS_BYTE: begin
				// Eight bits then the ninth acknowledge bit; a one released lets the far side answer.
				if (!st_ff.wait_eng) begin
					nxt_st.cmd = '{go: 1'b1, kind: EK_BIT, tx: st_ff.sh[8]};
					nxt_st.wait_eng = 1'b1;
				end else if (eng_rsp.done) begin
					nxt_st.wait_eng = 1'b0;
					nxt_st.sh = {st_ff.sh[7:0], eng_rsp.rx};
					nxt_st.nbits = st_ff.nbits - 4'd1;
					if (st_ff.nbits == 4'd1) begin
						// A silent device (wrong selects or busy writing) ends the transfer.
						case (st_ff.stage)
							SG_CTRL: begin
								if (eng_rsp.rx) begin
									nxt_st.nack = 1'b1;
									nxt_st.ms = MS_STOP;
								end else begin
									nxt_st.stage = SG_AHI;
									nxt_st.sh = {1'b0, st_ff.waddr[14:8], 1'b1};
									nxt_st.nbits = 4'd9;
								end
							end
							SG_AHI: begin
								nxt_st.stage = SG_ALO;
								nxt_st.sh = {st_ff.waddr[7:0], 1'b1};
								nxt_st.nbits = 4'd9;
								nxt_st.nack = eng_rsp.rx;
								nxt_st.ms = eng_rsp.rx ? MS_STOP : MS_BYTE;
							end
							SG_ALO: begin
								nxt_st.idx = '0;
								nxt_st.nack = eng_rsp.rx;
								if (eng_rsp.rx) begin
									nxt_st.ms = MS_STOP;
								end else if (st_ff.rd) begin
									nxt_st.stage = SG_CTRLR;
									nxt_st.ms = MS_START;
								end else begin
									nxt_st.stage = SG_WDATA;
									nxt_st.ms = MS_LOAD;
								end
							end
							SG_WDATA: begin
								// Count is at most one page; the host never wraps past it.
								if (eng_rsp.rx) begin
									nxt_st.nack = 1'b1;
									nxt_st.ms = MS_STOP;
								end else if (st_ff.idx == st_ff.cnt) begin
									nxt_st.ms = MS_STOP;
								end else begin
									nxt_st.idx = st_ff.idx + 1'b1;
									nxt_st.ms = MS_LOAD;
								end
							end
							SG_CTRLR: begin
								nxt_st.nack = eng_rsp.rx;
								nxt_st.stage = SG_RDATA;
								nxt_st.sh = {8'hFF, st_ff.cnt == '0};
								nxt_st.nbits = 4'd9;
								nxt_st.ms = eng_rsp.rx ? MS_STOP : MS_BYTE;
							end
							SG_RDATA: begin
								nxt_st.mem = '{en: 1'b1, we: 1'b1, addr: st_ff.idx, wdata: st_ff.sh[7:0]};
								nxt_st.ms = MS_STORE;
							end
							default: begin
								nxt_st.ms = MS_STOP;
								if (!eng_rsp.rx) begin
									nxt_st.stage = SG_CTRL;
								end
							end
						endcase
					end
				end
			end
			MS_LOAD: begin
				nxt_st.mem = '{en: 1'b1, we: 1'b0, addr: st_ff.idx, wdata: 8'h00};
				nxt_st.ms = MS_FETCH;
			end
			MS_FETCH: begin
				nxt_st.sh = {mem_rdata, 1'b1};
				nxt_st.nbits = 4'd9;
				nxt_st.ms = MS_BYTE;
			end
			MS_STORE: begin
				if (st_ff.idx == st_ff.cnt) begin
					nxt_st.ms = MS_STOP;
				end else begin
					// Acknowledge every byte but the last, which is left unacknowledged.
					nxt_st.idx = st_ff.idx + 1'b1;
					nxt_st.sh = {8'hFF, (st_ff.idx + 1'b1) == st_ff.cnt};
					nxt_st.nbits = 4'd9;
					nxt_st.ms = MS_BYTE;
				end
			end
			MS_STOP: begin
				if (!st_ff.wait_eng) begin
					nxt_st.cmd = '{go: 1'b1, kind: EK_STOP, tx: 1'b1};
					nxt_st.wait_eng = 1'b1;
				end else if (eng_rsp.done) begin
					nxt_st.wait_eng = 1'b0;
					nxt_st.ms = MS_DONE;
					if (st_ff.stage == SG_WDATA && !st_ff.nack && st_ff.poll && !st_ff.wp) begin
						// The write cycle runs now; poll until the device answers or 5 ms pass.
						nxt_st.stage = SG_POLL;
						nxt_st.timer = 32'h0000_0000;
						nxt_st.ms = MS_START;
					end else if (st_ff.stage == SG_POLL) begin
						if (st_ff.timer == POLL_LAST) begin
							nxt_st.tout = 1'b1;
						end else begin
							nxt_st.ms = MS_START;
						end
					end
				end
			end
			MS_DONE: begin
				nxt_st.busy = 1'b0;
				nxt_st.stage = SG_CTRL;
				nxt_st.ms = MS_IDLE;
				done_set = 1'b1;
			end
			default: nxt_st.ms = MS_IDLE;
		endcase

		// Completion set wins over a clear written in the same cycle.
		if (done_set) begin
			nxt_st.done = 1'b1;
		end
		if (st_ff.ms == MS_DONE && st_ff.stage == SG_POLL) begin
			nxt_st.nack = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '{ms: MS_IDLE, stage: SG_CTRL, wait_eng: 1'b0, sh: 9'h1FF, nbits: 4'd0,
				idx: '0, timer: 32'h0000_0000, cmd: '{go: 1'b0, kind: EK_BIT, tx: 1'b1},
				mem: '{en: 1'b0, we: 1'b0, addr: '0, wdata: 8'h00}, ack: 1'b0,
				dat: 32'h0000_0000, wb_ph: 2'd0, rd: CTRL_RESET[CTRL_RD],
				poll: CTRL_RESET[CTRL_POLL], wp: CTRL_RESET[CTRL_WP],
				cnt: CTRL_RESET[CTRL_CNT_LO +: IDX_W], waddr: ADDR_RESET[ADDR_WORD_LO +: WADDR_W],
				cs: ADDR_RESET[ADDR_CS_LO +: 3], busy: 1'b0, done: 1'b0, nack: 1'b0,
				tout: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign wb_ack_o = st_ff.ack;
	assign wb_dat_o = st_ff.dat;
	// Held from a register through the whole command, so the Stop samples a steady level.
	assign wp_o = st_ff.wp;

endmodule

/* File: eeh_host_props.sv */
// Checker of the host's ports: Wishbone answer timing and the shapes on the two-wire link.
// Assumes it is bound to the host and sees nothing but the host's own ports.
`timescale 1ns/1ps
module eeh_host_props
	import eeh_pkg::*;
#(
	parameter int QUARTER = QUARTER_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [8:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic scl_o,
	input wire logic sda_o,
	input wire logic sda_oe_n_o,
	input wire logic wp_o
);
	// Length of the current clock high time; it saturates so that idle stretches stay cheap.
	logic [9:0] hi_cnt_ff;
	logic [9:0] nxt_hi_cnt;
	always_comb begin
		nxt_hi_cnt = hi_cnt_ff;
		if (!scl_o) begin
			nxt_hi_cnt = '0;
		end else if (hi_cnt_ff != '1) begin
			nxt_hi_cnt = hi_cnt_ff + 1'b1;
		end
	end
	always_ff @(posedge clk_i) begin
		hi_cnt_ff <= rst_i ? '0 : nxt_hi_cnt;
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack stood longer than one cycle");
	a_ack_in_cycle: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
		else $error("ack outside a bus cycle");
	a_reg_ack_time: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_adr_i[8]
		|=> wb_ack_o) else $error("register access not answered next cycle");
	a_buf_ack_late: assert property ($rose(wb_stb_i) && wb_adr_i[8] |=> !wb_ack_o)
		else $error("buffer access answered too early");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 9'h00c
		|-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
	a_idle_after_reset: assert property ($fell(rst_i) |-> scl_o && sda_oe_n_o)
		else $error("link not idle after reset");
	a_start_shape: assert property ($fell(sda_oe_n_o) && scl_o |-> scl_o [*3])
		else $error("start not held with clock high");
	a_stop_shape: assert property ($rose(sda_oe_n_o) && scl_o |-> scl_o [*3])
		else $error("stop not followed by idle clock");
	a_clock_pulse: assert property ($fell(scl_o) |-> hi_cnt_ff >= 10'(2 * QUARTER))
		else $error("clock high time too short");
	a_open_drain: assert property (sda_o == 1'b0)
		else $error("data line driven high");
	a_wp_steady: assert property ($changed(wp_o) |-> $past(wb_we_i) && $past(wb_stb_i))
		else $error("protect level moved without a register write");
endmodule
bind eeh_host eeh_host_props #(.QUARTER(QUARTER)) i_props (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.scl_o(scl_o), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .wp_o(wp_o)
);

/* File: eeh_mem_model.sv */
// Behavioural serial memory on the two-wire link: control byte, pointer, page buffer,
// protection and a timed write cycle during which it stays silent.
// Assumes the line has a pull-up and that the master makes the clock.
`timescale 1ns/1ps
module eeh_mem_model #(
	parameter logic [3:0] TYPE_CODE = 4'h0,
	parameter logic [2:0] CS = 3'h0,
	parameter int WC_NS = 2400
) (
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic wp_i,
	output logic pull_o
);
	logic [7:0] mem [32768];
	logic [7:0] pbuf [64];
	logic [7:0] sh;
	logic [14:0] ptr;
	logic lscl, lsda, wrote, mack, rdgo;
	int nb, ph;
	time busy_end;
	initial begin
		for (int i = 0; i < 32768; i++) begin
			mem[i] = 8'(i) ^ 8'h3c;
		end
		{lscl, lsda, wrote, mack, rdgo, pull_o} = 6'b110000;
		{nb, busy_end} = '0;
		ph = 5;
	end
	always @(scl_i or sda_i) begin
		if (scl_i && lscl && lsda && !sda_i) begin
			ph = 0;
			nb = 0;
			wrote = 1'b0;
			pull_o = 1'b0;
		end else if (scl_i && lscl && !lsda && sda_i) begin
			if (wrote && !wp_i) begin
				for (int i = 0; i < 64; i++) begin
					mem[{ptr[14:6], 6'(i)}] = pbuf[i];
				end
				busy_end = $time + WC_NS;
			end
			ph = 5;
			wrote = 1'b0;
			pull_o = 1'b0;
		end else if (scl_i && !lscl) begin
			nb++;
			if (ph != 4 && nb <= 8) sh = {sh[6:0], sda_i};
			if (ph == 4 && nb == 9) mack = !sda_i;
		end else if (!scl_i && lscl) begin
			if (nb == 8 && ph != 4) begin
				case (ph)
					0: if ($time >= busy_end && sh[7:4] == TYPE_CODE && sh[3:1] == CS) begin
						ph = sh[0] ? 4 : 1;
						rdgo = sh[0];
						pull_o = 1'b1;
					end else begin
						ph = 5;
					end
					1: begin
						ptr[14:8] = sh[6:0];
						ph = 2;
						pull_o = 1'b1;
					end
					2: begin
						ptr[7:0] = sh;
						for (int i = 0; i < 64; i++) pbuf[i] = mem[{ptr[14:6], 6'(i)}];
						ph = 3;
						pull_o = 1'b1;
					end
					3: begin
						pbuf[ptr[5:0]] = sh;
						ptr[5:0] = ptr[5:0] + 6'h1;
						wrote = 1'b1;
						pull_o = 1'b1;
					end
					default: ;
				endcase
			end else if (nb == 8) begin
				pull_o = 1'b0;
			end else if (nb == 9) begin
				nb = 0;
				if (ph == 4 && (rdgo || mack)) begin
					rdgo = 1'b0;
					mack = 1'b0;
					sh = mem[ptr];
					ptr++;
					pull_o = !sh[7];
				end else begin
					pull_o = 1'b0;
					if (ph == 4) ph = 5;
				end
			end else if (ph == 4 && nb > 0) begin
				pull_o = !sh[7 - nb];
			end
		end
		lscl = scl_i;
		lsda = sda_i;
	end
endmodule

/* File: tb_eeh_host.sv */
// Testbench of the serial memory host: Wishbone tasks, a memory model on the link, scenarios.
// Assumes small QUARTER and POLL_CYCLES values so that the run stays short.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
	$display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
module tb_eeh_host;
	import eeh_pkg::*;
	localparam logic [3:0] TCODE = 4'h9; // Arbitrary type code, shared by host and model.
	localparam logic [2:0] CS = 3'h5;
	logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, scl, sda_o, sda_oe_n, wp, pull;
	logic [8:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_dat, wb_rdat, rdat, stat;
	int mismatches, total_checks;
	wire sda_w = (sda_oe_n | sda_o) & !pull;
	eeh_host #(.DEV_TYPE_CODE(TCODE), .POLL_CYCLES(2000), .QUARTER(4)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat),
		.wb_ack_o(wb_ack), .scl_o(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
		.wp_o(wp));
	eeh_mem_model #(.TYPE_CODE(TCODE), .CS(CS), .WC_NS(2400)) i_mem (.scl_i(scl),
		.sda_i(sda_w), .wp_i(wp), .pull_o(pull));
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [8:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_dat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 20000);
		if (n >= 20000) begin
			mismatches++;
			conclude();
		end
		rdat = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask
	// Flags are {protect, poll, read, go}; done is cleared first so each status is fresh.
	task automatic cmd(input logic [14:0] wa, input logic [2:0] cs, input logic [3:0] fl,
		input logic [5:0] cnt);
		int n;
		bus(1'b1, OFS_ADDR, {13'h0, cs, 1'b0, wa});
		bus(1'b1, OFS_STAT, 32'h0000_0002);
		bus(1'b1, OFS_CTRL, {18'h0, cnt, 4'h0, fl});
		n = 0;
		do begin
			bus(1'b0, OFS_STAT, 32'h0000_0000);
			n++;
		end while (rdat[STAT_BUSY] !== 1'b0 && n < 8000);
		if (n >= 8000) begin
			mismatches++;
			conclude();
		end
		stat = rdat;
	endtask
	task automatic t_reset();
		bus(1'b0, OFS_CTRL, 32'h0000_0000);
		`CHK("ctrl reset", CTRL_RESET, rdat)
		bus(1'b0, OFS_ADDR, 32'h0000_0000);
		`CHK("addr reset", ADDR_RESET, rdat)
		bus(1'b0, OFS_STAT, 32'h0000_0000);
		`CHK("stat reset", 32'h0000_0000, rdat)
		bus(1'b1, 9'h00c, 32'hffff_ffff);
		bus(1'b0, 9'h00c, 32'h0000_0000);
		`CHK("unmapped", 32'h0000_0000, rdat)
		$display("test reset done");
	endtask
	// Eight bytes from four before a page end must wrap to the page start.
	task automatic t_page();
		logic [7:0] e;
		for (int i = 0; i < 8; i++) bus(1'b1, 9'h100 + 9'(4 * i), 32'(8'ha0 + 8'(i)));
		cmd(15'h123c, CS, 4'h5, 6'd7);
		`CHK("page write status", 3'b001, stat[3:1])
		cmd(15'h1200, CS, 4'h3, 6'd63);
		`CHK("page read status", 3'b001, stat[3:1])
		for (int i = 0; i < 64; i++) begin
			e = 8'(i) ^ 8'h3c;
			if (i >= 60) e = 8'ha0 + 8'(i - 60);
			if (i < 4) e = 8'ha4 + 8'(i);
			bus(1'b0, 9'h100 + 9'(4 * i), 32'h0000_0000);
			`CHK("page byte", e, rdat[7:0])
		end
		$display("test page done");
	endtask
	task automatic t_protect();
		bus(1'b1, 9'h100, 32'h0000_0077);
		cmd(15'h0010, CS, 4'h9, 6'd0);
		`CHK("protect pin", 1'b1, wp)
		`CHK("protected ack", 3'b001, stat[3:1])
		cmd(15'h0010, CS, 4'h3, 6'd0);
		`CHK("accepted at once", 3'b001, stat[3:1])
		bus(1'b0, 9'h100, 32'h0000_0000);
		`CHK("protected byte", 8'h2c, rdat[7:0])
		$display("test protect done");
	endtask
	task automatic t_busy();
		bus(1'b1, 9'h100, 32'h0000_00c3);
		cmd(15'h0321, CS, 4'h1, 6'd0);
		`CHK("byte write", 3'b001, stat[3:1])
		cmd(15'h0321, CS, 4'h1, 6'd0);
		`CHK("busy refusal", 1'b1, stat[STAT_NACK])
		// Lets the model's write cycle run out before the next write.
		repeat (400) @(posedge clk_i);
		bus(1'b1, 9'h100, 32'h0000_005a);
		cmd(15'h0321, CS, 4'h5, 6'd0);
		`CHK("poll clears", 3'b001, stat[3:1])
		cmd(15'h0321, CS, 4'h3, 6'd0);
		bus(1'b0, 9'h100, 32'h0000_0000);
		`CHK("written byte", 8'h5a, rdat[7:0])
		cmd(15'h0000, 3'h2, 4'h3, 6'd0);
		`CHK("foreign select", 1'b1, stat[STAT_NACK])
		$display("test busy done");
	endtask
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	initial begin
		{rst_i, wb_cyc, wb_stb, wb_we} = 4'b1000;
		wb_adr = 9'h000;
		wb_sel = 4'hf;
		wb_dat = 32'h0000_0000;
		mismatches = 0;
		total_checks = 0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_page();
		t_protect();
		t_busy();
		conclude();
	end
endmodule
